/* File: inc/sastof_pkg.sv */
// Purpose: Constants and types of the target link layer open framer.
// Assumes: 20 MHz clock, APB register access with 32-bit words.
// Notes: Frame fields are packed big-endian, byte zero in bits 31:24.
package sastof_pkg;
  // Clock and timing
  localparam int CLK_NS = 50;
  localparam int US_NS = 1000;
  localparam int US_PER_MS = 1000;
  localparam int CYC_PER_US = US_NS / CLK_NS;
  localparam int IDF_TMO_MS = 1;
  localparam int ACKNAK_TMO_MS = 1;
  localparam int IDF_TMO_CYC = IDF_TMO_MS * US_PER_MS * CYC_PER_US;
  localparam int ACKNAK_TMO_CYC = ACKNAK_TMO_MS * US_PER_MS * CYC_PER_US;

  // Register byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_DEST_LO = 12'h004;
  localparam logic [11:0] REG_DEST_HI = 12'h008;
  localparam logic [11:0] REG_SRC_LO = 12'h00c;
  localparam logic [11:0] REG_SRC_HI = 12'h010;
  localparam logic [11:0] REG_STATUS = 12'h014;
  localparam logic [11:0] REG_CLEAR = 12'h018;
  localparam logic [11:0] REG_ENABLE = 12'h01c;
  localparam logic [11:0] REG_INFO = 12'h020;
  localparam logic [11:0] REG_TAG = 12'h024;

  // Control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RATE_LSB = 4;
  localparam int NUM_EV = 5;
  localparam int EV_IDF_TMO = 0;
  localparam int EV_BRK_ABORT = 1;
  localparam int EV_RESP_FAIL = 2;
  localparam int EV_OPEN_SENT = 3;
  localparam int EV_PATH_BLK = 4;

  // Frame fields
  localparam logic INIT_PORT_BIT = 1'b0;
  localparam logic [2:0] PROTO_SSP = 3'h1;
  localparam logic [3:0] FTYPE_OPEN = 4'h1;
  localparam logic [3:0] FEATURES_ZERO = 4'h0;
  localparam logic [3:0] RATE_1G5 = 4'h8;
  localparam logic [3:0] RATE_3G = 4'h9;
  localparam logic [3:0] RATE_6G = 4'ha;
  localparam logic [3:0] RATE_12G = 4'hb;
  localparam logic [7:0] ZONE_ZERO = 8'h00;
  localparam logic [31:0] MCF_ZERO = 32'h0000_0000;
  localparam logic [7:0] PBC_MAX = 8'hff;
  localparam logic [15:0] AWT_US_MAX = 16'h7fff;
  localparam logic [15:0] AWT_MS_BASE = 16'h8000;
  localparam logic [15:0] AWT_MS_MAX = 16'hffff;
  localparam logic [2:0] FRAME_LAST = 3'h7;
  localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
  localparam logic [31:0] ALIGN_DW = 32'hbc4a_4a7b;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10
  } sastof_state_t;
endpackage : sastof_pkg

/* File: hw/sastof_link.sv */
// Purpose: Target link layer: connection request frame builder and link error handling.
// Assumes: Link-side inputs synchronous to i_clk; event inputs are one-cycle pulses.
// Notes: APB slave adds one wait state; all outputs are registered.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sastof_link
  import sastof_pkg::*;
#(
  parameter int IDF_CYC = IDF_TMO_CYC,
  parameter int ACKNAK_CYC = ACKNAK_TMO_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_phy_ready,
  input wire logic [3:0] i_phy_rate,
  input wire logic i_tx_ready,
  output logic [31:0] o_tx_dword,
  output logic o_tx_valid,
  output logic o_tx_align,
  input wire logic i_idf_rcvd,
  input wire logic i_rx_tag_vld,
  input wire logic [15:0] i_rx_tag,
  input wire logic [63:0] i_rx_src,
  input wire logic i_open_accept,
  input wire logic i_open_rej_pb,
  input wire logic i_break_rcvd,
  input wire logic i_acknak_bal,
  input wire logic i_frames_pending,
  input wire logic i_resp_sent,
  input wire logic i_resp_ack,
  input wire logic i_resp_nak,
  output logic o_cominit,
  output logic o_break_reply,
  output logic o_cmd_abort,
  output logic o_resp_resend,
  output logic o_resp_rtx,
  output logic o_irq
);

  localparam logic [15:0] IDF_LAST = 16'(IDF_CYC - 1);
  localparam logic [15:0] ACKNAK_LAST = 16'(ACKNAK_CYC - 1);
  localparam logic [4:0] US_LAST = 5'(CYC_PER_US - 1);
  localparam logic [9:0] MS_LAST = 10'(US_PER_MS - 1);

  function automatic logic sastof_hit(input logic [11:0] a);
    case (a)
      REG_CTRL, REG_DEST_LO, REG_DEST_HI, REG_SRC_LO, REG_SRC_HI,
      REG_STATUS, REG_CLEAR, REG_ENABLE, REG_INFO, REG_TAG: sastof_hit = 1'b1;
      default: sastof_hit = 1'b0;
    endcase
  endfunction : sastof_hit

  // Serial CRC, most significant bit first
  function automatic logic [31:0] sastof_crc(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ({r[30:0], 1'b0} ^ CRC_POLY) : {r[30:0], 1'b0};
    end
    return r;
  endfunction : sastof_crc

  sastof_state_t state_r;
  logic [3:0] rate_r;
  logic [31:0] dest_lo_r, dest_hi_r, src_lo_r, src_hi_r;
  logic [NUM_EV-1:0] status_r, enable_r, ev, clr;
  logic [15:0] tag_r, awt_r, idf_cnt_r, resp_cnt_r;
  logic tag_vld_r, idf_done_r, resp_run_r, resp_try_r, pend_r;
  logic [7:0] pbc_r;
  logic [2:0] idx_r, al_r, n_align;
  logic [3:0] gap;
  logic [31:0] crc_r, fw, rd_mux;
  logic [4:0] us_div_r;
  logic [9:0] ms_div_r;
  logic us_tick, wr, start_wr, ld, last_ld, launch, pb, reopen, waiting;
  logic idf_tmo, resp_tmo, resp_resend, resp_fail;

  // APB: access completes at the edge where pready is already high
  assign wr = i_psel & i_penable & o_pready & i_pwrite & sastof_hit(i_paddr);
  assign start_wr = wr & (i_paddr == REG_CTRL) & i_pwdata[CTRL_START_BIT];
  assign clr = (wr && i_paddr == REG_CLEAR) ? i_pwdata[NUM_EV-1:0] : '0;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      REG_CTRL: rd_mux = {22'h0, state_r, rate_r, 4'h0};
      REG_DEST_LO: rd_mux = dest_lo_r;
      REG_DEST_HI: rd_mux = dest_hi_r;
      REG_SRC_LO: rd_mux = src_lo_r;
      REG_SRC_HI: rd_mux = src_hi_r;
      REG_STATUS: rd_mux = {27'h0, status_r};
      REG_ENABLE: rd_mux = {27'h0, enable_r};
      REG_INFO: rd_mux = {8'h00, pbc_r, awt_r};
      REG_TAG: rd_mux = {tag_vld_r, 15'h0, tag_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_psel && i_penable && !o_pready) begin
      o_pready <= 1'b1;
      o_prdata <= i_pwrite ? 32'h0000_0000 : rd_mux;
      o_pslverr <= ~sastof_hit(i_paddr);
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rate_r <= RATE_1G5;
      dest_lo_r <= 32'h0000_0000;
      dest_hi_r <= 32'h0000_0000;
      src_lo_r <= 32'h0000_0000;
      src_hi_r <= 32'h0000_0000;
      enable_r <= '0;
    end else if (wr) begin
      case (i_paddr)
        REG_CTRL: rate_r <= i_pwdata[CTRL_RATE_LSB +: 4];
        REG_DEST_LO: dest_lo_r <= i_pwdata;
        REG_DEST_HI: dest_hi_r <= i_pwdata;
        REG_SRC_LO: src_lo_r <= i_pwdata;
        REG_SRC_HI: src_hi_r <= i_pwdata;
        REG_ENABLE: enable_r <= i_pwdata[NUM_EV-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      status_r <= '0;
      o_irq <= 1'b0;
    end else begin
      status_r <= (status_r & ~clr) | ev;
      o_irq <= |(((status_r & ~clr) | ev) & enable_r);
    end
  end

  // Tag from the initiator we address; other initiators do not disturb it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tag_r <= 16'h0000;
      tag_vld_r <= 1'b0;
    end else if (i_rx_tag_vld && i_rx_src == {dest_hi_r, dest_lo_r}) begin
      tag_r <= i_rx_tag;
      tag_vld_r <= 1'b1;
    end
  end

  // Identification timer restarts with every phy reset sequence
  assign idf_tmo = i_phy_ready & ~idf_done_r & ~i_idf_rcvd & (idf_cnt_r == IDF_LAST);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_phy_ready) begin
      idf_cnt_r <= 16'h0000;
      idf_done_r <= 1'b0;
    end else if (i_idf_rcvd || idf_tmo) begin
      idf_done_r <= 1'b1;
    end else if (!idf_done_r) begin
      idf_cnt_r <= idf_cnt_r + 16'h0001;
    end
  end

  // RESPONSE frame retry: at most one resend, then report failure
  assign resp_tmo = resp_run_r & ~i_resp_ack & ~i_resp_nak & (resp_cnt_r == ACKNAK_LAST);
  assign resp_resend = ~i_resp_sent & resp_run_r & ~resp_try_r & (i_resp_nak | resp_tmo);
  assign resp_fail = ~i_resp_sent & resp_run_r & resp_try_r & (i_resp_nak | resp_tmo);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      resp_run_r <= 1'b0;
      resp_try_r <= 1'b0;
      resp_cnt_r <= 16'h0000;
    end else if (i_resp_sent) begin
      resp_run_r <= 1'b1;
      resp_try_r <= 1'b0;
      resp_cnt_r <= 16'h0000;
    end else if (i_resp_ack || resp_fail) begin
      resp_run_r <= 1'b0;
    end else if (resp_resend) begin
      resp_try_r <= 1'b1;
      resp_cnt_r <= 16'h0000;
    end else if (resp_run_r) begin
      resp_cnt_r <= resp_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_resp_resend <= 1'b0;
      o_resp_rtx <= 1'b0;
      o_cominit <= 1'b0;
      o_break_reply <= 1'b0;
      o_cmd_abort <= 1'b0;
    end else begin
      o_resp_resend <= resp_resend;
      if (resp_resend) begin
        o_resp_rtx <= ~i_resp_nak;
      end
      o_cominit <= idf_tmo;
      o_break_reply <= i_break_rcvd;
      o_cmd_abort <= i_break_rcvd & ~i_acknak_bal;
    end
  end

  always_comb begin
    ev = '0;
    ev[EV_IDF_TMO] = idf_tmo;
    ev[EV_BRK_ABORT] = i_break_rcvd & ~i_acknak_bal;
    ev[EV_RESP_FAIL] = resp_fail;
    ev[EV_OPEN_SENT] = last_ld;
    ev[EV_PATH_BLK] = pb;
  end

  // Connection request scheduling
  assign pb = i_open_rej_pb & (state_r == ST_WAIT);
  assign reopen = i_break_rcvd & i_acknak_bal & i_frames_pending;
  assign launch = (state_r == ST_IDLE) & pend_r & i_phy_ready & ~i_break_rcvd;
  assign ld = ~o_tx_valid | i_tx_ready;
  // Sent event only when dword 7 really leaves; a cut frame reports nothing
  assign last_ld = (state_r == ST_SEND) & ld & i_phy_ready & ~i_break_rcvd &
                   (al_r == 3'h0) & (idx_r == FRAME_LAST);
  assign waiting = pend_r | (state_r != ST_IDLE);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= start_wr | reopen | pb | (pend_r & ~launch);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
    end else if (i_break_rcvd || !i_phy_ready) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: if (launch) state_r <= ST_SEND;
        ST_SEND: if (last_ld) state_r <= ST_WAIT;
        ST_WAIT: if (i_open_accept || pb) state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Count survives retries, restarts with a fresh request or an accept
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_open_accept || (start_wr && state_r == ST_IDLE && !pend_r)) begin
      pbc_r <= 8'h00;
    end else if (pb && pbc_r != PBC_MAX) begin
      pbc_r <= pbc_r + 8'h01;
    end
  end

  // Microsecond enable from the clock divider
  assign us_tick = (us_div_r == US_LAST);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || us_tick) begin
      us_div_r <= 5'h00;
    end else begin
      us_div_r <= us_div_r + 5'h01;
    end
  end

  // Arbitration wait: microsecond steps, then millisecond steps, saturating
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !waiting) begin
      awt_r <= 16'h0000;
      ms_div_r <= 10'h000;
    end else if (us_tick) begin
      if (awt_r < AWT_US_MAX) begin
        awt_r <= awt_r + 16'h0001;
      end else if (awt_r == AWT_US_MAX) begin
        awt_r <= AWT_MS_BASE;
      end else if (ms_div_r == MS_LAST) begin
        ms_div_r <= 10'h000;
        if (awt_r != AWT_MS_MAX) begin
          awt_r <= awt_r + 16'h0001;
        end
      end else begin
        ms_div_r <= ms_div_r + 10'h001;
      end
    end
  end

  // Frame dwords, byte zero in the top byte
  always_comb begin
    fw = 32'h0000_0000;
    case (idx_r)
      3'h0: fw = {INIT_PORT_BIT, PROTO_SSP, FTYPE_OPEN, FEATURES_ZERO, rate_r, tag_r};
      3'h1: fw = dest_hi_r;
      3'h2: fw = dest_lo_r;
      3'h3: fw = src_hi_r;
      3'h4: fw = src_lo_r;
      3'h5: fw = {ZONE_ZERO, pbc_r, awt_r};
      3'h6: fw = MCF_ZERO;
      default: fw = ~crc_r;
    endcase
  end

  // Slot ratio between physical rate and connection rate
  assign gap = i_phy_rate - rate_r;
  assign n_align = (i_phy_rate > rate_r) ? 3'((4'h1 << gap[1:0]) - 4'h1) : 3'h0;

  // Transmit slot register; i_tx_ready back-pressures the frame
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_tx_dword <= 32'h0000_0000;
      o_tx_valid <= 1'b0;
      o_tx_align <= 1'b0;
      idx_r <= 3'h0;
      al_r <= 3'h0;
      crc_r <= CRC_INIT;
    end else if (launch) begin
      idx_r <= 3'h0;
      al_r <= 3'h0;
      crc_r <= CRC_INIT;
      if (ld) begin
        o_tx_valid <= 1'b0;
        o_tx_align <= 1'b0;
      end
    end else if (state_r == ST_SEND && ld && i_phy_ready && !i_break_rcvd) begin
      o_tx_valid <= 1'b1;
      if (al_r != 3'h0) begin
        o_tx_dword <= ALIGN_DW;
        o_tx_align <= 1'b1;
        al_r <= al_r - 3'h1;
      end else begin
        o_tx_dword <= fw;
        o_tx_align <= 1'b0;
        idx_r <= idx_r + 3'h1;
        if (idx_r != FRAME_LAST) begin
          crc_r <= sastof_crc(crc_r, fw);
          al_r <= n_align;
        end
      end
    end else if (ld) begin
      o_tx_valid <= 1'b0;
      o_tx_align <= 1'b0;
    end
  end

endmodule : sastof_link

`default_nettype wire

/* File: testbench/sastof_link_props.sv */
// Purpose: Port assertions of the target open framer.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every instance of the framer.
`timescale 1ns/1ps
`default_nettype none
module sastof_link_props
  import sastof_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic i_phy_ready,
  input wire logic i_tx_ready,
  input wire logic [31:0] o_tx_dword,
  input wire logic o_tx_valid,
  input wire logic o_tx_align,
  input wire logic i_break_rcvd,
  input wire logic i_acknak_bal,
  input wire logic i_resp_nak,
  input wire logic o_break_reply,
  input wire logic o_cmd_abort,
  input wire logic o_resp_resend,
  input wire logic o_resp_rtx,
  input wire logic o_cominit
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_acc;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_nak_rsd;
    i_resp_nak ##[1:2] o_resp_resend;
  endsequence
  AST_PREADY: assert property (s_acc |=> o_pready ##1 !o_pready)
    else $error("pready timing wrong");
  AST_TX_PHY: assert property ($rose(o_tx_valid) |-> $past(i_phy_ready))
    else $error("frame started without phy ready");
  AST_TX_HOLD: assert property (o_tx_valid && !i_tx_ready && i_phy_ready && !i_break_rcvd
    |=> o_tx_valid && $stable(o_tx_dword))
    else $error("dword not held");
  AST_ALIGN: assert property (o_tx_valid && o_tx_align |-> o_tx_dword == ALIGN_DW)
    else $error("filler dword wrong");
  AST_BRK_REPLY: assert property (i_break_rcvd |=> o_break_reply)
    else $error("no break reply");
  AST_ABORT: assert property (i_break_rcvd && !i_acknak_bal |-> ##[1:2] o_cmd_abort)
    else $error("no command abort");
  AST_NO_ABORT: assert property (i_break_rcvd && i_acknak_bal |=> !o_cmd_abort [*2])
    else $error("abort while balanced");
  AST_NAK_RTX: assert property (s_nak_rsd |-> !o_resp_rtx)
    else $error("retransmit bit set after nak");
  AST_COMINIT: assert property (o_cominit |=> !o_cominit)
    else $error("cominit not a pulse");
endmodule : sastof_link_props
bind sastof_link sastof_link_props u_sastof_link_props (.*);
`default_nettype wire

/* File: testbench/sastof_peer.sv */
// Purpose: Far-side link sink that captures outgoing frame dwords.
// Assumes: Frames run to completion once started.
// Notes: Stall toggles ready each cycle to exercise holding.
`timescale 1ns/1ps
`default_nettype none
module sastof_peer (
  input wire logic i_clk,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire logic i_align,
  input wire logic [31:0] i_dword,
  output logic o_ready
);
  logic [31:0] dw [8];
  logic [2:0] n_dw = 3'h0;
  int n_frames = 0;
  int n_align = 0;
  initial o_ready = 1'b1;
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      if (i_align) begin
        n_align <= n_align + 1;
      end else begin
        dw[n_dw] <= i_dword;
        n_dw <= n_dw + 3'h1;
        if (n_dw == 3'h7) n_frames <= n_frames + 1;
      end
    end
    o_ready <= i_stall ? !o_ready : 1'b1;
  end
endmodule : sastof_peer
`default_nettype wire

/* File: testbench/sastof_link_tb.sv */
// Purpose: Self-checking bench of the target open framer.
// Assumes: Both timeouts shortened to 40 cycles.
// Notes: Expected frames are rebuilt here, CRC included.
`timescale 1ns/1ps
`default_nettype none
module sastof_link_tb;
  import sastof_pkg::*;
  localparam int TMO = 40;
  localparam logic [63:0] DST = 64'h5000_c500_1122_3344;
  localparam logic [63:0] SRC = 64'h5000_c500_aabb_ccdd;
  logic i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, o_tx_dword, rd;
  logic i_phy_ready = 0, i_idf_rcvd = 0, i_rx_tag_vld = 0, i_open_accept = 0;
  logic i_open_rej_pb = 0, i_break_rcvd = 0, i_acknak_bal = 1, i_frames_pending = 0;
  logic i_resp_sent = 0, i_resp_ack = 0, i_resp_nak = 0, stall = 1;
  logic [3:0] i_phy_rate = 4'h9;
  logic [15:0] i_rx_tag = 16'h0;
  logic [63:0] i_rx_src = 64'h0;
  logic o_pready, o_pslverr, i_tx_ready, o_tx_valid, o_tx_align, o_cominit;
  logic o_break_reply, o_cmd_abort, o_resp_resend, o_resp_rtx, o_irq, err;
  int n_errors = 0, checked = 0, cyc = 0, n_com = 0, n_abt = 0, n_rsd = 0, n_brp = 0, n, t0;
  always #25 i_clk = ~i_clk;
  sastof_link #(.IDF_CYC(TMO), .ACKNAK_CYC(TMO)) u_sastof_link (.*);
  sastof_peer u_sastof_peer (.i_clk(i_clk), .i_stall(stall), .i_valid(o_tx_valid),
    .i_align(o_tx_align), .i_dword(o_tx_dword), .o_ready(i_tx_ready));
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_cominit === 1'b1) n_com <= n_com + 1;
    if (o_cmd_abort === 1'b1) n_abt <= n_abt + 1;
    if (o_resp_resend === 1'b1) n_rsd <= n_rsd + 1;
    if (o_break_reply === 1'b1) n_brp <= n_brp + 1;
    if (cyc == 30000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR t=%0t %s", $time, m);
    end
  endtask : chk
  // Release only after pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wait_frame(input int k);
    repeat (400) if (u_sastof_peer.n_frames < k) @(posedge i_clk);
    chk(u_sastof_peer.n_frames == k, "frame missing");
  endtask : wait_frame
  task automatic chk_frame(input logic [7:0] pbc);
    logic [31:0] c;
    c = 32'hffff_ffff;
    for (int k = 0; k < 7; k++)
      for (int b = 31; b >= 0; b--)
        c = {c[30:0], 1'b0} ^ (c[31] ^ u_sastof_peer.dw[k][b] ? 32'h04c1_1db7 : 32'h0);
    chk(u_sastof_peer.dw[0] === 32'h1108_1234, "header dword");
    chk(u_sastof_peer.dw[1] === DST[63:32] && u_sastof_peer.dw[2] === DST[31:0], "dst");
    chk(u_sastof_peer.dw[3] === SRC[63:32] && u_sastof_peer.dw[4] === SRC[31:0], "src");
    chk(u_sastof_peer.dw[5][31:16] === {8'h00, pbc}, "zone or count");
    chk(u_sastof_peer.dw[6] === 32'h0, "features");
    chk(u_sastof_peer.dw[7] === ~c, "crc");
  endtask : chk_frame
  task automatic t_regs();
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd === 32'h0, "status reset");
    apb(1'b0, 12'h100, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped");
    apb(1'b1, REG_ENABLE, 32'h1f);
    apb(1'b0, REG_ENABLE, 32'h0);
    chk(rd[4:0] === 5'h1f, "enable");
    $display("t_regs done");
  endtask : t_regs
  task automatic t_idf();
    n = 0;
    @(posedge i_clk);
    i_phy_ready <= 1'b1;
    while (n_com == 0 && n < 60) begin
      @(posedge i_clk);
      n++;
    end
    chk(n >= TMO - 1 && n <= TMO + 4, "identify timeout");
    i_idf_rcvd <= 1'b1;
    @(posedge i_clk);
    i_idf_rcvd <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[0] === 1'b1 && o_irq === 1'b1, "identify event");
    apb(1'b1, REG_CLEAR, 32'h1);
    repeat (2) @(posedge i_clk);
    chk(o_irq === 1'b0, "irq clear");
    $display("t_idf done");
  endtask : t_idf
  task automatic t_open();
    apb(1'b1, REG_DEST_HI, DST[63:32]);
    apb(1'b1, REG_DEST_LO, DST[31:0]);
    apb(1'b1, REG_SRC_HI, SRC[63:32]);
    apb(1'b1, REG_SRC_LO, SRC[31:0]);
    @(posedge i_clk);
    i_rx_src <= DST;
    i_rx_tag <= 16'h1234;
    i_rx_tag_vld <= 1'b1;
    // Tag from another initiator must not replace it
    @(posedge i_clk);
    i_rx_src <= SRC;
    i_rx_tag <= 16'hdead;
    @(posedge i_clk);
    i_rx_tag_vld <= 1'b0;
    // Request made while the phy is down must wait for it
    i_phy_ready <= 1'b0;
    t0 = cyc;
    apb(1'b1, REG_CTRL, 32'h81);
    repeat (30) @(posedge i_clk);
    chk(u_sastof_peer.n_frames == 0 && o_tx_valid === 1'b0, "frame before phy ready");
    i_phy_ready <= 1'b1;
    wait_frame(1);
    chk_frame(8'h00);
    apb(1'b0, REG_TAG, 32'h0);
    chk(rd === 32'h8000_1234, "tag register");
    chk(u_sastof_peer.n_align == 7, "align count");
    $display("t_open done");
  endtask : t_open
  task automatic t_pb();
    for (int i = 2; i <= 257; i++) begin
      @(posedge i_clk);
      i_open_rej_pb <= 1'b1;
      @(posedge i_clk);
      i_open_rej_pb <= 1'b0;
      wait_frame(i);
      if (i == 2) chk_frame(8'h01);
    end
    chk_frame(8'hff);
    n = (cyc - t0) / 20;
    chk(u_sastof_peer.dw[5][15:0] <= n && u_sastof_peer.dw[5][15:0] + 4 >= n, "wait");
    @(posedge i_clk);
    i_open_accept <= 1'b1;
    @(posedge i_clk);
    i_open_accept <= 1'b0;
    apb(1'b0, REG_INFO, 32'h0);
    chk(rd === 32'h0, "info after accept");
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[4:3] === 2'b11, "sent and blocked events");
    $display("t_pb done");
  endtask : t_pb
  task automatic t_brk();
    apb(1'b1, REG_CLEAR, 32'h1f);
    @(posedge i_clk);
    i_frames_pending <= 1'b1;
    i_break_rcvd <= 1'b1;
    @(posedge i_clk);
    i_break_rcvd <= 1'b0;
    wait_frame(258);
    i_frames_pending <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[1] === 1'b0 && n_abt == 0 && n_brp == 1, "balanced break");
    i_open_accept <= 1'b1;
    i_acknak_bal <= 1'b0;
    i_break_rcvd <= 1'b1;
    @(posedge i_clk);
    i_open_accept <= 1'b0;
    i_break_rcvd <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[1] === 1'b1 && n_abt == 1 && n_brp == 2, "unbalanced break");
    i_acknak_bal <= 1'b1;
    $display("t_brk done");
  endtask : t_brk
  task automatic t_resp();
    @(posedge i_clk);
    i_resp_sent <= 1'b1;
    @(posedge i_clk);
    i_resp_sent <= 1'b0;
    i_resp_nak <= 1'b1;
    @(posedge i_clk);
    i_resp_nak <= 1'b0;
    repeat (5) if (n_rsd == 0) @(posedge i_clk);
    chk(n_rsd == 1 && o_resp_rtx === 1'b0, "nak resend");
    repeat (TMO + 10) @(posedge i_clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(n_rsd == 1 && rd[2] === 1'b1, "single retry");
    n = 0;
    i_resp_sent <= 1'b1;
    @(posedge i_clk);
    i_resp_sent <= 1'b0;
    while (n_rsd == 1 && n < 80) begin
      @(posedge i_clk);
      n++;
    end
    chk(n >= TMO - 2 && n <= TMO + 4 && o_resp_rtx === 1'b1, "timeout resend");
    i_resp_ack <= 1'b1;
    @(posedge i_clk);
    i_resp_ack <= 1'b0;
    $display("t_resp done");
  endtask : t_resp
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_idf();
    t_open();
    t_pb();
    t_brk();
    t_resp();
    report_and_stop();
  end
endmodule : sastof_link_tb
`default_nettype wire
